// >>> inc/scanner_pkg.sv
/*
  Shared constants and carrier types for the sensor matrix scanner.
  Assumes a 16 by 8 switch matrix behind an external 4-to-16 row decoder.
*/
package scanner_pkg;

  localparam int ROWS         = 16;
  localparam int COLS         = 8;
  localparam int ROW_W        = 4;
  localparam int COL_W        = 3;
  localparam int COL_CNT_W    = 4;
  localparam int SCAN_W       = 16;

  localparam logic [ROW_W-1:0]     ROW_FIRST = 4'h0;
  localparam logic [ROW_W-1:0]     ROW_LAST  = 4'hf;
  localparam logic [COL_CNT_W-1:0] COL_IDLE  = 4'h0;
  localparam logic [COL_CNT_W-1:0] COL_PRESET = 4'h8;

  // Event byte layout: state in bit 7, row in 6..3, column in 2..0.
  localparam int EV_STATE_POS = 7;
  localparam int EV_ROW_MSB   = 6;
  localparam int EV_ROW_LSB   = 3;
  localparam int EV_COL_MSB   = 2;
  localparam int EV_COL_LSB   = 0;
  localparam int EV_W         = 8;

  // Queue occupies locations bottom..top inclusive.
  localparam int QUEUE_BOTTOM = 0;
  localparam int QUEUE_TOP    = 39;
  localparam int BUF_DEPTH    = 8;

  localparam logic [SCAN_W-1:0] SCAN_INTERVAL_RST = 16'h0000;

  typedef struct packed {
    logic             closed;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } event_t;

  typedef struct packed {
    logic queue_pending;
    logic output_buffer_full;
  } status_t;

endpackage

// >>> verilog/sensor_matrix_scanner.sv
/*
  Sensor matrix scanner with its event queue.
  Assumes synchronous column inputs, a host read strobe of one cycle and an
  external decoder that pulls the addressed row low.
*/
// Function
// - Handle 16 rows by 8 columns, one previous-state bit per sensor.
// - Drive a 4-bit row number to an external 4-to-16 decoder.
// - Selected row low; a low column reads closed, high reads open.
// - XOR present row with stored row; nonzero means something changed.
// - Previous-state map is 16 bytes, one byte per row.
// - After comparing a row, store its new column states in the map.
// - Each change yields one event byte offered via the output buffer.
// - Output buffer occupied: new events enter a 40-entry queue.
// - Queue is circular with write and read pointers that wrap.
// - Queue depth follows top and bottom address parameters.
// - Queue-pending flag on status and pin while queue holds events.
// - Buffer-full and queue-pending visible as status and as pins.
// - Queue not empty and buffer free moves oldest event into buffer.
// - Column counter rests at zero, used only for rows with changes.
// - Event coordinate combines row counter and column counter.
// - Reset clears counters, pointers, outputs and all status flags.
// - After reset scan whole matrix once as baseline, then detect.
// - Row without changes gets one service step, then next row.
// - Within a changed row, service after every single bit test.
// - After the last row, restart at the first row.
// - Event bit 7 carries present state, other bits the coordinate.
// - Column counter preset to 8, decremented per left shift test.
// - Loading the buffer sets full; a host read clears it.
// - Queue full and buffer occupied halts scanning until a read.
`timescale 1ns/100ps

module event_queue #(
  parameter int WIDTH = scanner_pkg::EV_W,
  parameter int DEPTH = scanner_pkg::BUF_DEPTH
)(
  // Clock, reset and enable.
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  import scanner_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_reg;
  logic [PW-1:0]    wr_next;
  logic [PW-1:0]    rd_reg;
  logic [PW-1:0]    rd_next;
  logic [CW-1:0]    cnt_reg;
  logic [CW-1:0]    cnt_next;
  logic             push;
  logic             pop;

  // Both pointers step from the top location back to the bottom.
  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    ptr_step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  always_comb
  begin
    in_ready  = (cnt_reg != CW'(DEPTH));
    out_valid = (cnt_reg != '0);
    out_data  = mem[rd_reg];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_next   = push ? ptr_step(wr_reg) : wr_reg;
    rd_next   = pop ? ptr_step(rd_reg) : rd_reg;
    cnt_next  = cnt_reg;
    if (push && !pop)
    begin
      cnt_next = CW'(cnt_reg + 1'b1);
    end
    else if (pop && !push)
    begin
      cnt_next = CW'(cnt_reg - 1'b1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else if (ce)
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce && push)
    begin
      mem[wr_reg] <= in_data;
    end
  end

endmodule

module sensor_matrix_scanner #(
  parameter int QUEUE_BOTTOM = scanner_pkg::QUEUE_BOTTOM,
  parameter int QUEUE_TOP    = scanner_pkg::QUEUE_TOP
)(
  // Clock, reset and enable.
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              ce,
  // Matrix pins.
  output logic [scanner_pkg::ROW_W-1:0]          row_select,
  input  wire logic [scanner_pkg::COLS-1:0]      column_return_n,
  // Configuration.
  input  wire logic [scanner_pkg::SCAN_W-1:0]    scan_interval,
  // Host side.
  input  wire logic                              host_read,
  output scanner_pkg::event_t                    host_output_buffer,
  output scanner_pkg::status_t                   status,
  output logic                                   queue_pending_irq_pin,
  output logic                                   buffer_full_irq_pin
);
  import scanner_pkg::*;

  localparam int QUEUE_DEPTH = QUEUE_TOP - QUEUE_BOTTOM + 1;

  typedef enum logic [1:0] {ST_SETTLE, ST_SHIFT, ST_SERVICE} state_t;

  logic [COLS-1:0]      map_mem [ROWS];
  state_t               state_reg;
  state_t               state_next;
  logic [ROW_W-1:0]     row_index_counter_reg;
  logic [ROW_W-1:0]     row_index_counter_next;
  logic [COL_CNT_W-1:0] column_index_counter_reg;
  logic [COL_CNT_W-1:0] column_index_counter_next;
  logic [COLS-1:0]      row_difference_reg;
  logic [COLS-1:0]      row_difference_next;
  logic [COLS-1:0]      present_reg;
  logic [COLS-1:0]      present_next;
  logic [SCAN_W-1:0]    wait_reg;
  logic [SCAN_W-1:0]    wait_next;
  logic                 baseline_reg;
  logic                 baseline_next;
  event_t               buf_reg;
  event_t               buf_next;
  logic                 full_reg;
  logic                 full_next;
  logic                 pend_reg;
  logic                 map_we;
  logic [COLS-1:0]      present_now;
  logic [COLS-1:0]      diff_now;
  logic [COL_W-1:0]     col_found;
  event_t               event_byte_store;
  logic                 ev_found;
  logic                 direct_ok;
  logic                 stall;
  logic                 load_direct;
  logic                 load_queue;
  logic                 q_in_valid;
  logic                 q_in_ready;
  logic                 q_out_valid;
  logic [EV_W-1:0]      q_out_data;

  event_queue #(
    .WIDTH (EV_W),
    .DEPTH (QUEUE_DEPTH)
  ) queue_i (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .in_data   (event_byte_store),
    .out_valid (q_out_valid),
    .out_ready (load_queue),
    .out_data  (q_out_data)
  );

  // Event routing and output buffer.
  always_comb
  begin
    col_found = COL_W'(column_index_counter_reg - 1'b1);
    event_byte_store.closed = present_reg[col_found];
    event_byte_store.row    = row_index_counter_reg;
    event_byte_store.col    = col_found;
    ev_found    = (state_reg == ST_SHIFT) && row_difference_reg[COLS-1];
    // The buffer is loaded directly only when nothing older waits.
    direct_ok   = !full_reg && !q_out_valid;
    load_direct = ev_found && direct_ok;
    q_in_valid  = ev_found && !direct_ok;
    stall       = ev_found && !direct_ok && !q_in_ready;
    load_queue  = !full_reg && q_out_valid;
    buf_next    = buf_reg;
    if (load_direct)
    begin
      buf_next = event_byte_store;
    end
    else if (load_queue)
    begin
      buf_next = event_t'(q_out_data);
    end
    // A load in the cycle of a read keeps the flag set.
    full_next = full_reg;
    if (load_direct || load_queue)
    begin
      full_next = 1'b1;
    end
    else if (host_read)
    begin
      full_next = 1'b0;
    end
  end

  // Scan sequencer.
  always_comb
  begin
    present_now               = ~column_return_n;
    diff_now                  = present_now ^ map_mem[row_index_counter_reg];
    state_next                = state_reg;
    row_index_counter_next    = row_index_counter_reg;
    column_index_counter_next = column_index_counter_reg;
    row_difference_next       = row_difference_reg;
    present_next              = present_reg;
    wait_next                 = wait_reg;
    baseline_next             = baseline_reg;
    map_we                    = 1'b0;
    case (state_reg)
      ST_SETTLE:
      begin
        if (wait_reg != '0)
        begin
          wait_next = SCAN_W'(wait_reg - 1'b1);
        end
        else
        begin
          present_next = present_now;
          map_we       = 1'b1;
          if (baseline_reg)
          begin
            // Baseline pass: fill the map without reporting anything.
            baseline_next = (row_index_counter_reg != ROW_LAST);
            row_index_counter_next = (row_index_counter_reg == ROW_LAST) ?
              ROW_FIRST : ROW_W'(row_index_counter_reg + 1'b1);
            wait_next = scan_interval;
          end
          else if (diff_now == '0)
          begin
            state_next = ST_SERVICE;
          end
          else
          begin
            column_index_counter_next = COL_PRESET;
            row_difference_next       = diff_now;
            state_next                = ST_SHIFT;
          end
        end
      end
      ST_SHIFT:
      begin
        if (!stall)
        begin
          row_difference_next       = row_difference_reg << 1;
          column_index_counter_next =
            COL_CNT_W'(column_index_counter_reg - 1'b1);
          state_next                = ST_SERVICE;
        end
      end
      ST_SERVICE:
      begin
        if (column_index_counter_reg != COL_IDLE)
        begin
          state_next = ST_SHIFT;
        end
        else
        begin
          row_index_counter_next = (row_index_counter_reg == ROW_LAST) ?
            ROW_FIRST : ROW_W'(row_index_counter_reg + 1'b1);
          wait_next  = scan_interval;
          state_next = ST_SETTLE;
        end
      end
      default:
      begin
        state_next = ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg                <= ST_SETTLE;
      row_index_counter_reg    <= ROW_FIRST;
      column_index_counter_reg <= COL_IDLE;
      row_difference_reg       <= '0;
      present_reg              <= '0;
      wait_reg                 <= SCAN_INTERVAL_RST;
      baseline_reg             <= 1'b1;
      buf_reg                  <= '0;
      full_reg                 <= 1'b0;
      pend_reg                 <= 1'b0;
    end
    else if (ce)
    begin
      state_reg                <= state_next;
      row_index_counter_reg    <= row_index_counter_next;
      column_index_counter_reg <= column_index_counter_next;
      row_difference_reg       <= row_difference_next;
      present_reg              <= present_next;
      wait_reg                 <= wait_next;
      baseline_reg             <= baseline_next;
      buf_reg                  <= buf_next;
      full_reg                 <= full_next;
      pend_reg                 <= q_out_valid;
    end
  end

  // The map has no reset; the baseline pass writes every row first.
  always_ff @(posedge clk)
  begin
    if (ce && map_we)
    begin
      map_mem[row_index_counter_reg] <= present_now;
    end
  end

  assign row_select                = row_index_counter_reg;
  assign host_output_buffer        = buf_reg;
  assign status.output_buffer_full = full_reg;
  assign status.queue_pending      = pend_reg;
  assign buffer_full_irq_pin       = full_reg;
  assign queue_pending_irq_pin     = pend_reg;

  // Checks.
  full_on_load_a: assert property (@(posedge clk) disable iff (rst)
    ce && (load_direct || load_queue) |=> buffer_full_irq_pin)
    else $error("buffer full flag not set by load");
  read_clears_a: assert property (@(posedge clk) disable iff (rst)
    ce && full_reg && host_read |=> !status.output_buffer_full)
    else $error("host read did not clear full flag");
  pend_track_a: assert property (@(posedge clk) disable iff (rst)
    ce |=> queue_pending_irq_pin == $past(q_out_valid))
    else $error("queue pending pin does not track queue");
  drain_queue_a: assert property (@(posedge clk) disable iff (rst)
    ce && q_out_valid && !full_reg
    |=> full_reg && host_output_buffer == $past(q_out_data))
    else $error("oldest queued event not moved to buffer");
  col_rest_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_SETTLE |-> column_index_counter_reg == COL_IDLE)
    else $error("column counter not at rest between rows");
  col_preset_a: assert property (@(posedge clk) disable iff (rst)
    ce && state_reg == ST_SETTLE && wait_reg == '0 && !baseline_reg
    && diff_now != '0 |=> column_index_counter_reg == COL_PRESET)
    else $error("column counter not preset to eight");
  event_coord_a: assert property (@(posedge clk) disable iff (rst)
    ce && load_direct |=> host_output_buffer.row == $past(row_select)
    && host_output_buffer.col == $past(col_found))
    else $error("event coordinate wrong");
  halt_hold_a: assert property (@(posedge clk) disable iff (rst)
    ce && stall |=> state_reg == ST_SHIFT
    && column_index_counter_reg == $past(column_index_counter_reg))
    else $error("scan advanced while queue and buffer full");
  row_wrap_a: assert property (@(posedge clk) disable iff (rst)
    ce && state_reg == ST_SERVICE && column_index_counter_reg == COL_IDLE
    && row_select == ROW_LAST |=> row_select == ROW_FIRST)
    else $error("row counter did not wrap to first row");
  base_quiet_a: assert property (@(posedge clk) disable iff (rst)
    baseline_reg |-> state_reg == ST_SETTLE && !ev_found)
    else $error("event reported during baseline pass");
  bit_service_a: assert property (@(posedge clk) disable iff (rst)
    ce && state_reg == ST_SHIFT && !stall |=> state_reg == ST_SERVICE)
    else $error("no service step after bit test");

  direct_cov: cover property (@(posedge clk) disable iff (rst)
    ce && load_direct);
  queued_cov: cover property (@(posedge clk) disable iff (rst)
    ce && q_in_valid && q_in_ready);
  stall_cov: cover property (@(posedge clk) disable iff (rst)
    ce && stall ##[1:200] ce && !stall);
  wrap_cov: cover property (@(posedge clk) disable iff (rst)
    ce && !baseline_reg && row_select == ROW_LAST ##1 row_select == ROW_FIRST);

endmodule

// >>> sim/host_master_model.sv
/*
  Behavioural host that drains the scanner's output buffer.
  Assumes the bench reads and clears the captured bytes in the got queue.
*/
`timescale 1ns/100ps

module host_master_model
(
  // Clock, reset and enable.
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Pacing from the bench.
  input  wire logic       enable,
  input  wire logic [3:0] delay,
  // Scanner host side.
  input  wire logic       full_pin,
  input  wire logic [7:0] buffer,
  output logic            host_read
);
  logic [7:0] got [$];
  int         wait_cnt;

  // The strobe is held until an edge with ce high, since a read taken on a
  // frozen edge would be lost while the host believed it had the byte.
  always @(posedge clk)
  begin
    if (rst)
    begin
      host_read <= 1'b0;
      wait_cnt  <= 0;
    end
    else if (host_read)
    begin
      if (ce)
      begin
        got.push_back(buffer);
        host_read <= 1'b0;
        wait_cnt  <= 0;
      end
    end
    else if (enable && full_pin === 1'b1)
    begin
      if (wait_cnt >= delay)
        host_read <= 1'b1;
      else
        wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// >>> sim/tb_sensor_matrix_scanner.sv
/*
  Self-checking bench for the sensor matrix scanner.
  Assumes the host model in host_master_model.sv and the scanner package.
*/
`timescale 1ns/100ps

module tb_sensor_matrix_scanner;
  import scanner_pkg::*;

  localparam int LIMIT = 40000;

  logic              clk;
  logic              rst;
  logic              ce;
  logic [ROW_W-1:0]  row_select;
  logic [COLS-1:0]   column_return_n;
  logic [SCAN_W-1:0] scan_interval;
  logic              host_read;
  event_t            host_output_buffer;
  status_t           status;
  logic              queue_pending_irq_pin;
  logic              buffer_full_irq_pin;
  logic              rd_enable;
  logic [3:0]        rd_delay;
  logic              ce_jitter;
  logic [COLS-1:0]   closed [ROWS];
  logic [7:0]        expq [$];
  logic [ROW_W-1:0]  last_row;
  logic [ROW_W-1:0]  held_row;
  logic [1:0]        pins;
  int                seed;
  int                ce_seed;
  int                num_errors;
  int                check_count;
  int                cycles;

  // The modelled matrix: a closed sensor on the selected row pulls low.
  assign column_return_n = ~closed[row_select];
  assign pins            = {queue_pending_irq_pin, buffer_full_irq_pin};

  sensor_matrix_scanner u_sensor_matrix_scanner (
    .clk                   (clk),
    .rst                   (rst),
    .ce                    (ce),
    .row_select            (row_select),
    .column_return_n       (column_return_n),
    .scan_interval         (scan_interval),
    .host_read             (host_read),
    .host_output_buffer    (host_output_buffer),
    .status                (status),
    .queue_pending_irq_pin (queue_pending_irq_pin),
    .buffer_full_irq_pin   (buffer_full_irq_pin)
  );

  host_master_model u_host_master_model (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .enable    (rd_enable),
    .delay     (rd_delay),
    .full_pin  (buffer_full_irq_pin),
    .buffer    (host_output_buffer),
    .host_read (host_read)
  );

  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] ev(input logic st, input int r, input int c);
    return {st, 4'(r), 3'(c)};
  endfunction

  // Flip sensors of one row and queue the events, highest column first.
  task automatic flip_row(input int r, input logic [COLS-1:0] mask);
    logic [COLS-1:0] nxt;
    nxt = closed[r] ^ mask;
    for (int c = COLS - 1; c >= 0; c--)
      if (mask[c])
        expq.push_back(ev(nxt[c], r, c));
    closed[r] <= nxt;
  endtask

  // Waits for n bytes, then a further settle time to catch extra events.
  task automatic wait_events(input int n, input int extra);
    int k;
    k = 0;
    while (u_host_master_model.got.size() < n && k < 5000)
    begin
      @(posedge clk);
      k++;
    end
    repeat (extra) @(posedge clk);
  endtask

  task automatic compare_events();
    logic [7:0] got [$];
    got = u_host_master_model.got;
    check("event count", got.size(), expq.size());
    foreach (expq[i])
      if (i < got.size())
      begin
        check("event state", got[i][7], expq[i][7]);
        check("event row", got[i][6:3], expq[i][6:3]);
        check("event col", got[i][2:0], expq[i][2:0]);
      end
    expq.delete();
    u_host_master_model.got.delete();
  endtask

  task automatic check_idle();
    check("row_select", row_select, ROW_FIRST);
    check("buffer", host_output_buffer, 8'h00);
    check("status", status, 2'h0);
    check("pins", pins, 2'h0);
  endtask

  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles >= LIMIT)
    begin
      num_errors = num_errors + 1;
      test_done();
    end
  end

  always @(posedge clk)
    ce <= ce_jitter ? (($random(ce_seed) & 7) != 0) : 1'b1;

  // Rows must step by one and wrap from the last row to the first.
  always @(posedge clk)
  begin
    if (rst)
      last_row <= ROW_FIRST;
    else if (row_select !== last_row)
    begin
      check("row step", row_select, 4'(last_row + 4'h1));
      last_row <= row_select;
    end
    if (!rst)
    begin
      check("full pin", buffer_full_irq_pin, status[0]);
      check("pend pin", queue_pending_irq_pin, status[1]);
    end
  end

  initial
  begin
    seed          = 71197;
    ce_seed       = 71197;
    num_errors    = 0;
    check_count   = 0;
    cycles        = 0;
    rst           = 1'b1;
    scan_interval = 16'h0000;
    rd_enable     = 1'b1;
    rd_delay      = 4'h0;
    ce_jitter     = 1'b0;
    foreach (closed[r])
      closed[r] = 8'($random(seed));
    repeat (4) @(posedge clk);
    check_idle();
    rst           <= 1'b0;
    scan_interval <= 16'({$random(seed)} % 5);
    repeat (180) @(posedge clk);
    check("baseline events", u_host_master_model.got.size(), 0);
    for (int n = 0; n < 12; n++)
    begin
      int r;
      logic [COLS-1:0] m;
      r = {$random(seed)} % ROWS;
      m = 8'($random(seed));
      if (n == 0)
      begin
        r = 15;
        m = 8'hff;
      end
      if (n == 1)
      begin
        r = 0;
        m = 8'h01;
      end
      if (m == 8'h00)
        m = 8'h81;
      rd_delay  <= (n % 2 == 1) ? 4'h6 : 4'h0;
      ce_jitter <= (n >= 6);
      flip_row(r, m);
      wait_events(expq.size(), 400);
      compare_events();
    end
    // Stall the host so the queue fills behind a full buffer.
    ce_jitter <= 1'b0;
    rd_enable <= 1'b0;
    while (row_select !== 4'h1)
      @(posedge clk);
    for (int r = 2; r < 8; r++)
      flip_row(r, 8'hff);
    repeat (600) @(posedge clk);
    held_row = row_select;
    check("pending", status.queue_pending, 1'b1);
    check("irq pins", pins, 2'h3);
    repeat (50) @(posedge clk);
    check("halted row", row_select, held_row);
    rd_enable <= 1'b1;
    wait_events(48, 60);
    compare_events();
    check("drained status", status, 2'h0);
    check("drained pins", pins, 2'h0);
    // Reset in mid-run with events pending.
    rd_enable <= 1'b0;
    flip_row(9, 8'h3c);
    repeat (300) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(posedge clk);
    check_idle();
    rst <= 1'b0;
    expq.delete();
    u_host_master_model.got.delete();
    // The new baseline must absorb the row flipped before the reset.
    rd_enable <= 1'b1;
    repeat (180) @(posedge clk);
    check("rebase events", u_host_master_model.got.size(), 0);
    test_done();
  end
endmodule
